/* hw/fpu_flags_pkg.sv */
// package for the floating-point status and repeat-block bookkeeping block
// assumes a single core clock; shared by the design and its bench
package fpu_flags_pkg;
  localparam int STATUS_W = 32;
  localparam int LOOP_W = 32;
  localparam int PC_W = 22;
  localparam int NUM_FREGS = 8;
  // status word bit positions
  localparam int SB_SHADOW = 31;
  localparam int SB_RND = 9;
  localparam int SB_TF = 6;
  localparam int SB_ZI = 5;
  localparam int SB_NI = 4;
  localparam int SB_ZF = 3;
  localparam int SB_NF = 2;
  localparam int SB_LUF = 1;
  localparam int SB_LVF = 0;
  localparam logic [31:0] STATUS_WRITABLE = 32'h0000027F;
  // repeat word layout
  localparam int LB_SHADOW = 31;
  localparam int LB_ACTIVE = 30;
  localparam int LB_SIZE_LO = 23;
  localparam int LB_SIZE_W = 7;
  localparam int LB_END_LO = 16;
  localparam int LB_END_W = 7;
  localparam int LB_CNT_W = 16;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] LOOP_RESET = 32'h00000000;
  // register port addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_LOOP = 4'h1;
  localparam logic [3:0] ADDR_FREG0 = 4'h8;
  // flag-transfer select: one bit per status flag
  typedef struct packed {
    logic tf;
    logic zi;
    logic ni;
    logic zf;
    logic nf;
    logic latched_underflow_flag;
    logic latched_overflow_flag;
  } flag_sel_s;
  // core main status bits written by a flag transfer
  typedef struct packed {
    logic z;
    logic n;
    logic ov;
    logic tc;
    logic c;
  } core_flags_s;
  // arithmetic completion report
  typedef struct packed {
    logic valid;
    logic overflow;
    logic underflow;
  } math_event_s;
  typedef enum logic [2:0] {
    LOOP_IDLE = 3'b001,
    LOOP_RUN = 3'b010,
    LOOP_LAST = 3'b100
  } loop_state_e;
endpackage

/* hw/fpu_flags.sv */
// floating-point status word, shadow copies and repeat-block loop tracking
// assumes the pipeline presents one retiring instruction per strobe, aligned
`timescale 1ns/1ps
`default_nettype none
module fpu_flags #(
  parameter int PCW = fpu_flags_pkg::PC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic move_strobe,
  input wire logic [2:0] move_reg,
  input wire logic [31:0] move_value,
  input wire logic cmp_strobe,
  input wire logic [31:0] cmp_result,
  input wire fpu_flags_pkg::math_event_s math_event,
  input wire logic transfer_strobe,
  input wire fpu_flags_pkg::flag_sel_s transfer_sel,
  output fpu_flags_pkg::core_flags_s core_flags,
  output logic core_flags_valid,
  input wire logic flag_set_strobe,
  input wire logic [31:0] flag_set_mask,
  input wire logic [31:0] flag_set_value,
  input wire logic test_strobe,
  input wire logic test_true,
  input wire logic save_strobe,
  input wire logic restore_strobe,
  input wire logic status_load_strobe,
  input wire logic [31:0] status_load_value,
  input wire logic repeat_strobe,
  input wire logic [PCW-1:0] repeat_pc,
  input wire logic [6:0] repeat_size,
  input wire logic [15:0] repeat_count,
  input wire logic [PCW-1:0] pc,
  input wire logic pc_valid,
  input wire logic interrupt_taken,
  output logic loop_back,
  output logic round_nearest_even_enable,
  output logic overflow_irq,
  output logic underflow_irq,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic write,
  input wire logic read,
  output logic [31:0] rdata
);
  import fpu_flags_pkg::*;

  logic [31:0] float_status_word;
  logic [31:0] status_shadow;
  logic [31:0] repeat_loop_word;
  logic [31:0] fregs [NUM_FREGS];
  logic [31:0] fregs_shadow [NUM_FREGS];
  loop_state_e loop_state;
  logic [15:0] loop_repeat_count;
  logic [6:0] loop_end_address;
  logic loop_active_bit;
  logic loop_shadow_bit;
  logic mv_zf, mv_nf, cp_zf, cp_nf;
  logic at_end;
  logic [31:0] next_status;

  // ==========================================================
  // float classification
  function automatic logic f_zero(input logic [31:0] v);
    return v[30:23] == 8'h00;
  endfunction
  function automatic logic f_neg(input logic [31:0] v);
    return v[31] && !f_zero(v);
  endfunction

  assign mv_zf = f_zero(move_value);
  assign mv_nf = f_neg(move_value);
  assign cp_zf = f_zero(cmp_result);
  assign cp_nf = f_neg(cmp_result);

  // ==========================================================
  // status word next value; later items take priority
  always_comb begin
    next_status = float_status_word;
    if (restore_strobe) begin
      next_status = {float_status_word[SB_SHADOW], status_shadow[30:0]};
    end
    if (status_load_strobe) begin
      next_status = {float_status_word[SB_SHADOW], status_load_value[30:0] & STATUS_WRITABLE[30:0]};
    end
    if (write && addr == ADDR_STATUS) begin
      next_status = {float_status_word[SB_SHADOW], wdata[30:0] & STATUS_WRITABLE[30:0]};
    end
    if (flag_set_strobe) begin
      next_status = (next_status & ~(flag_set_mask & STATUS_WRITABLE))
                  | (flag_set_value & flag_set_mask & STATUS_WRITABLE);
    end
    if (move_strobe) begin
      next_status[SB_ZF] = mv_zf;
      next_status[SB_NF] = mv_nf;
      next_status[SB_ZI] = (move_value == 32'h00000000);
      next_status[SB_NI] = move_value[31];
    end
    if (cmp_strobe) begin
      next_status[SB_ZF] = cp_zf;
      next_status[SB_NF] = cp_nf;
    end
    if (test_strobe) begin
      next_status[SB_TF] = test_true;
    end
    if (transfer_strobe && transfer_sel.latched_overflow_flag) begin
      next_status[SB_LVF] = 1'b0;
    end
    if (transfer_strobe && transfer_sel.latched_underflow_flag) begin
      next_status[SB_LUF] = 1'b0;
    end
    // set wins over clear
    if (math_event.valid && math_event.overflow) begin
      next_status[SB_LVF] = 1'b1;
    end
    if (math_event.valid && math_event.underflow) begin
      next_status[SB_LUF] = 1'b1;
    end
    if (save_strobe) begin
      next_status[SB_SHADOW] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      float_status_word <= STATUS_RESET;
    end else begin
      float_status_word <= next_status;
    end
  end

  // ==========================================================
  // result registers and shadows
  generate
    for (genvar i = 0; i < NUM_FREGS; i++) begin : g_freg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fregs[i] <= 32'h00000000;
          fregs_shadow[i] <= 32'h00000000;
        end else begin
          if (save_strobe) begin
            fregs_shadow[i] <= fregs[i];
          end
          if (move_strobe && move_reg == 3'(i)) begin
            fregs[i] <= move_value;
          end else if (restore_strobe) begin
            fregs[i] <= fregs_shadow[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_shadow <= STATUS_RESET;
    end else if (save_strobe) begin
      status_shadow <= float_status_word;
    end
  end

  // ==========================================================
  // flag transfer to core main status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_flags <= '0;
      core_flags_valid <= 1'b0;
    end else begin
      core_flags_valid <= transfer_strobe;
      if (transfer_strobe) begin
        core_flags.z <= transfer_sel.zf ? float_status_word[SB_ZF] :
                        transfer_sel.zi ? float_status_word[SB_ZI] : 1'b0;
        core_flags.n <= transfer_sel.nf ? float_status_word[SB_NF] :
                        transfer_sel.ni ? float_status_word[SB_NI] : 1'b0;
        core_flags.ov <= transfer_sel.latched_overflow_flag && float_status_word[SB_LVF];
        core_flags.c <= transfer_sel.latched_underflow_flag && float_status_word[SB_LUF];
        core_flags.tc <= transfer_sel.tf && float_status_word[SB_TF];
      end
    end
  end

  // ==========================================================
  // mode and event outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      round_nearest_even_enable <= 1'b0;
      overflow_irq <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      round_nearest_even_enable <= next_status[SB_RND];
      overflow_irq <= next_status[SB_LVF];
      underflow_irq <= next_status[SB_LUF];
    end
  end

  // ==========================================================
  // repeat block tracking; block size is trusted as given by software
  assign at_end = pc_valid && pc[6:0] == loop_end_address;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_state <= LOOP_IDLE;
      loop_repeat_count <= 16'h0000;
      loop_end_address <= 7'h00;
      loop_active_bit <= 1'b0;
      loop_back <= 1'b0;
    end else begin
      loop_back <= 1'b0;
      if (repeat_strobe) begin
        loop_end_address <= 7'((repeat_pc[6:0]) + 7'h01 + repeat_size);
        loop_repeat_count <= repeat_count;
        loop_active_bit <= repeat_count != 16'h0000;
        loop_state <= (repeat_count != 16'h0000) ? LOOP_RUN : LOOP_LAST;
      end else begin
        unique case (loop_state)
          LOOP_IDLE: begin
          end
          LOOP_RUN: begin
            if (at_end) begin
              loop_back <= 1'b1;
              loop_repeat_count <= 16'(loop_repeat_count - 16'h0001);
              if (loop_repeat_count == 16'h0001) begin
                loop_active_bit <= 1'b0;
                loop_state <= LOOP_LAST;
              end
            end
          end
          LOOP_LAST: begin
            if (at_end) begin
              loop_state <= LOOP_IDLE;
            end
          end
          default: begin
            loop_state <= LOOP_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_shadow_bit <= 1'b0;
      repeat_loop_word <= LOOP_RESET;
    end else begin
      if (interrupt_taken) begin
        loop_shadow_bit <= loop_active_bit;
      end
      repeat_loop_word <= {loop_shadow_bit, loop_active_bit, repeat_strobe ? repeat_size :
                           repeat_loop_word[29:23], loop_end_address, loop_repeat_count};
    end
  end

  // ==========================================================
  // register port; repeat word ignores writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (read) begin
      if (addr == ADDR_STATUS) begin
        rdata <= float_status_word;
      end else if (addr == ADDR_LOOP) begin
        rdata <= repeat_loop_word;
      end else if (addr[3]) begin
        rdata <= fregs[addr[2:0]];
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // checks
  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    math_event.valid && math_event.overflow |=> float_status_word[SB_LVF])
    else $error("overflow not latched");
  AST_UNF_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    float_status_word[SB_LUF] && !transfer_strobe && !flag_set_strobe && !restore_strobe
    && !status_load_strobe && !write |=> float_status_word[SB_LUF])
    else $error("underflow dropped");
  AST_XFER_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    transfer_strobe && transfer_sel.latched_overflow_flag && !(math_event.valid && math_event.overflow)
    |=> !float_status_word[SB_LVF])
    else $error("overflow not cleared by transfer");
  AST_XFER_COPY: assert property (@(posedge clk) disable iff (!rst_n)
    transfer_strobe && transfer_sel.zf |=> core_flags_valid && core_flags.z == $past(float_status_word[SB_ZF]))
    else $error("zero flag not transferred");
  AST_SAVE_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
    save_strobe |=> float_status_word[SB_SHADOW])
    else $error("shadow bit not set");
  AST_MOVE_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    move_strobe && !cmp_strobe && move_value == 32'h80000000 |=> float_status_word[SB_ZF]
    && !float_status_word[SB_NF])
    else $error("negative zero misclassified");
  AST_END_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    repeat_strobe |=> loop_end_address == 7'($past(repeat_pc[6:0]) + 7'h01 + $past(repeat_size)))
    else $error("end address wrong");
  AST_ZERO_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    repeat_strobe && repeat_count == 16'h0000 |=> !loop_active_bit && loop_state == LOOP_LAST)
    else $error("zero count went active");
  AST_TEST_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    test_strobe && test_true |=> float_status_word[SB_TF])
    else $error("test flag not set");
  COV_LOOP_DONE: cover property (@(posedge clk) disable iff (!rst_n)
    loop_state == LOOP_RUN ##[1:200] loop_state == LOOP_IDLE);
  COV_XFER_OVF: cover property (@(posedge clk) disable iff (!rst_n)
    float_status_word[SB_LVF] && transfer_strobe && transfer_sel.latched_overflow_flag);
  COV_SAVE_RESTORE: cover property (@(posedge clk) disable iff (!rst_n)
    save_strobe ##[1:20] restore_strobe);
  COV_LOOP_INT: cover property (@(posedge clk) disable iff (!rst_n)
    interrupt_taken && loop_active_bit);
  AST_MOVE_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
    move_strobe && !cmp_strobe |=> float_status_word[SB_ZF] == $past(mv_zf)
    && float_status_word[SB_NF] == $past(mv_nf))
    else $error("move did not update float flags");
  AST_CMP_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_strobe |=> float_status_word[SB_ZF] == $past(cp_zf) && float_status_word[SB_NF] == $past(cp_nf))
    else $error("compare did not update float flags");
  AST_MOVE_INT: assert property (@(posedge clk) disable iff (!rst_n)
    move_strobe |=> float_status_word[SB_ZI] == ($past(move_value) == 32'h00000000)
    && float_status_word[SB_NI] == $past(move_value[31]))
    else $error("integer flags not updated by move");
  AST_ROUND_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    round_nearest_even_enable == float_status_word[SB_RND])
    else $error("rounding mode output disagrees with status");
  AST_IRQ_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_irq == float_status_word[SB_LVF] && underflow_irq == float_status_word[SB_LUF])
    else $error("latched flags not routed out");
  AST_LOOP_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    repeat_loop_word[LB_ACTIVE] == $past(loop_active_bit)
    && repeat_loop_word[LB_SHADOW] == $past(loop_shadow_bit))
    else $error("repeat word active bits wrong");
  AST_LOOP_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
    interrupt_taken |=> loop_shadow_bit == $past(loop_active_bit))
    else $error("loop shadow not captured");
  AST_LOOP_START: assert property (@(posedge clk) disable iff (!rst_n)
    repeat_strobe && repeat_count != 16'h0000 |=> loop_active_bit && loop_state == LOOP_RUN
    && loop_repeat_count == $past(repeat_count))
    else $error("repeat did not start active");
  AST_LOOP_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    !repeat_strobe && loop_state == LOOP_RUN && at_end |=> loop_back
    && loop_repeat_count == 16'($past(loop_repeat_count) - 16'h0001))
    else $error("repeat count not decremented at block end");
  AST_RESTORE_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
    restore_strobe && !status_load_strobe && !write && !flag_set_strobe && !move_strobe && !cmp_strobe
    && !test_strobe && !transfer_strobe && !math_event.valid && !save_strobe
    |=> float_status_word[30:0] == $past(status_shadow[30:0]))
    else $error("status not restored from shadow");
endmodule
`default_nettype wire

/* sim/core_pc_model.sv */
// pipeline model: steps the program counter one instruction per clock
// assumes the bench raises run to execute code and lowers it between tests
`timescale 1ns/1ps
`default_nettype none
module core_pc_model #(
  parameter int PCW = 22
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [PCW-1:0] start_pc,
  input wire logic loop_back,
  output logic [PCW-1:0] pc,
  output logic pc_valid
);
  // ==========================================
  // program counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= '0;
      pc_valid <= 1'b0;
    end else if (!run) begin
      // no fetch: address shows a changing pattern
      pc <= ~pc;
      pc_valid <= 1'b0;
    end else begin
      pc_valid <= 1'b1;
      if (!pc_valid || loop_back) begin
        pc <= start_pc;
      end else begin
        pc <= pc + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/fpu_flags_test.sv */
// bench for the float status word and repeat-block tracking
// assumes the design package and the pipeline model are compiled first
`timescale 1ns/1ps
`default_nettype none
module fpu_flags_test;
  import fpu_flags_pkg::*;
  typedef enum int {P_MOVE, P_CMP, P_MATH, P_XFER, P_SET, P_TEST, P_SAVE, P_RESTORE, P_LOAD, P_RPT, P_INT} pulse_e;
  logic clk = 1'b0, rst_n = 1'b0, move_strobe = 1'b0, cmp_strobe = 1'b0, transfer_strobe = 1'b0;
  logic flag_set_strobe = 1'b0, test_strobe = 1'b0, test_true = 1'b0, save_strobe = 1'b0, restore_strobe = 1'b0;
  logic status_load_strobe = 1'b0, repeat_strobe = 1'b0, interrupt_taken = 1'b0, write = 1'b0, read = 1'b0;
  logic [2:0] move_reg = 3'h0;
  logic [31:0] move_value = 32'h0, cmp_result = 32'h0, flag_set_mask = 32'h0, flag_set_value = 32'h0;
  logic [31:0] status_load_value = 32'h0, wdata = 32'h0, rdata;
  logic [3:0] addr = 4'h0;
  logic [6:0] repeat_size = 7'h0;
  logic [15:0] repeat_count = 16'h0;
  logic [PC_W-1:0] repeat_pc = '0, pc;
  logic pc_valid, core_flags_valid, loop_back, round_nearest_even_enable, overflow_irq, underflow_irq, run = 1'b0;
  math_event_s math_event = '0;
  flag_sel_s transfer_sel = '0;
  core_flags_s core_flags;
  int error_cnt = 0, n_tests = 0, hits = 0, backs = 0;
  logic [31:0] mv [6] = '{32'h80000000, 32'h00000001, 32'hC0000000, 32'h00000000, 32'h3F800000, 32'h80000001};
  logic [3:0] ms [6] = '{4'h6, 4'h2, 4'h5, 4'hA, 4'h0, 4'h6};

  always #25 clk = ~clk;

  fpu_flags dut_u (.clk(clk), .rst_n(rst_n), .move_strobe(move_strobe), .move_reg(move_reg), .move_value(move_value),
    .cmp_strobe(cmp_strobe), .cmp_result(cmp_result), .math_event(math_event), .transfer_strobe(transfer_strobe),
    .transfer_sel(transfer_sel), .core_flags(core_flags), .core_flags_valid(core_flags_valid),
    .flag_set_strobe(flag_set_strobe), .flag_set_mask(flag_set_mask), .flag_set_value(flag_set_value),
    .test_strobe(test_strobe), .test_true(test_true), .save_strobe(save_strobe), .restore_strobe(restore_strobe),
    .status_load_strobe(status_load_strobe), .status_load_value(status_load_value), .repeat_strobe(repeat_strobe),
    .repeat_pc(repeat_pc), .repeat_size(repeat_size), .repeat_count(repeat_count), .pc(pc), .pc_valid(pc_valid),
    .interrupt_taken(interrupt_taken), .loop_back(loop_back), .round_nearest_even_enable(round_nearest_even_enable),
    .overflow_irq(overflow_irq), .underflow_irq(underflow_irq), .addr(addr), .wdata(wdata), .write(write),
    .read(read), .rdata(rdata));

  core_pc_model #(.PCW(PC_W)) model_u (.clk(clk), .rst_n(rst_n), .run(run), .start_pc(repeat_pc + 22'h2),
    .loop_back(loop_back), .pc(pc), .pc_valid(pc_valid));

  // ==========================================
  // pass counters for the loop tests
  always @(posedge clk) begin
    if (pc_valid === 1'b1 && pc[6:0] === 7'h1A) hits++;
    if (loop_back === 1'b1) backs++;
  end

  // ==========================================
  // access tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input pulse_e k);
    case (k)
      P_MOVE: move_strobe <= 1'b1;
      P_CMP: cmp_strobe <= 1'b1;
      P_MATH: ;
      P_XFER: transfer_strobe <= 1'b1;
      P_SET: flag_set_strobe <= 1'b1;
      P_TEST: test_strobe <= 1'b1;
      P_SAVE: save_strobe <= 1'b1;
      P_RESTORE: restore_strobe <= 1'b1;
      P_LOAD: status_load_strobe <= 1'b1;
      P_RPT: repeat_strobe <= 1'b1;
      default: interrupt_taken <= 1'b1;
    endcase
    step(1);
    {move_strobe, cmp_strobe, transfer_strobe, flag_set_strobe, test_strobe} <= '0;
    {save_strobe, restore_strobe, status_load_strobe, repeat_strobe, interrupt_taken} <= '0;
    math_event <= '0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    read <= 1'b1;
    step(1);
    read <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    step(1);
    write <= 1'b0;
    #1;
  endtask

  task automatic run_loop(input int n);
    hits = 0;
    backs = 0;
    run <= 1'b1;
    step(n);
    run <= 1'b0;
    #1;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    step(5);
    rst_n <= 1'b1;
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_LOOP, 32'h0);
    rd(4'h2, 32'h0);
    for (int i = 0; i < 6; i++) begin
      move_reg <= 3'(i);
      move_value <= mv[i];
      pulse(P_MOVE);
      rd(ADDR_STATUS, {26'h0, ms[i], 2'h0});
      rd(ADDR_FREG0 | 4'(i), mv[i]);
    end
    cmp_result <= 32'hBF800000;
    pulse(P_CMP);
    rd(ADDR_STATUS, 32'h14);
    math_event <= 3'h6;
    pulse(P_MATH);
    math_event <= 3'h5;
    pulse(P_MATH);
    math_event <= 3'h4;
    pulse(P_MATH);
    rd(ADDR_STATUS, 32'h17);
    chk({30'h0, overflow_irq, underflow_irq}, 32'h3);
    transfer_sel <= 7'h0F;
    pulse(P_XFER);
    chk({26'h0, core_flags_valid, core_flags}, 32'h2D);
    rd(ADDR_STATUS, 32'h14);
    chk({30'h0, overflow_irq, underflow_irq}, 32'h0);
    test_true <= 1'b1;
    pulse(P_TEST);
    rd(ADDR_STATUS, 32'h54);
    transfer_sel <= 7'h70;
    pulse(P_XFER);
    chk({26'h0, core_flags_valid, core_flags}, 32'h2A);
    test_true <= 1'b0;
    pulse(P_TEST);
    rd(ADDR_STATUS, 32'h14);
    chk({31'h0, round_nearest_even_enable}, 32'h0);
    flag_set_mask <= 32'hFFFFFFFF;
    flag_set_value <= 32'hFFFFFFFF;
    pulse(P_SET);
    rd(ADDR_STATUS, 32'h27F);
    chk({31'h0, round_nearest_even_enable}, 32'h1);
    pulse(P_SAVE);
    rd(ADDR_STATUS, 32'h8000027F);
    pulse(P_LOAD);
    rd(ADDR_STATUS, 32'h80000000);
    move_reg <= 3'h0;
    move_value <= 32'h40000000;
    pulse(P_MOVE);
    pulse(P_RESTORE);
    rd(ADDR_STATUS, 32'h8000027F);
    rd(ADDR_FREG0, 32'h80000000);
    wr(ADDR_STATUS, 32'h40);
    rd(ADDR_STATUS, 32'h80000040);
    repeat_pc <= 22'h10;
    repeat_size <= 7'h9;
    repeat_count <= 16'h0;
    pulse(P_RPT);
    step(1);
    rd(ADDR_LOOP, 32'h049A0000);
    run_loop(60);
    chk(hits, 1);
    chk(backs, 0);
    repeat_count <= 16'h2;
    pulse(P_RPT);
    step(1);
    rd(ADDR_LOOP, 32'h449A0002);
    pulse(P_INT);
    step(2);
    rd(ADDR_LOOP, 32'hC49A0002);
    wr(ADDR_LOOP, 32'h0);
    rd(ADDR_LOOP, 32'hC49A0002);
    run_loop(60);
    chk(hits, 3);
    chk(backs, 2);
    rd(ADDR_LOOP, 32'h849A0000);
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
